// File: hdl/sccs_pkg.sv
// Shared constants and types for the system clock select block
package sccs_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CLK_SELECT = 8'h32;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h33;
  localparam logic [7:0] ADDR_REVISION = 8'h34;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [2:0] CLK_SELECT_RST = 3'h0;
  localparam logic [7:0] OSC_CTRL_RST = 8'h06;
  localparam int OSC_FORCE_ON_BIT = 2;
  localparam int OSC_POWER_BIT = 1;
  localparam int OSC_PIN_BIT = 0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ---------------------------------------------------------------
  // Clock sources
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_DIV1 = 3'b000,
    SRC_DIV2 = 3'b001,
    SRC_DIV4 = 3'b010,
    SRC_DIV8 = 3'b011,
    SRC_EXT  = 3'b100,
    SRC_RTC  = 3'b101
  } sccs_src_t;

  // Terminal counts of the oscillator divider, per half period
  localparam logic [2:0] DIV1_LIMIT = 3'h0;
  localparam logic [2:0] DIV2_LIMIT = 3'h1;
  localparam logic [2:0] DIV4_LIMIT = 3'h3;
  localparam logic [2:0] DIV8_LIMIT = 3'h7;

endpackage

// File: hdl/sccs_clk_if.sv
// Signals between the register side and the clock multiplexer
interface sccs_clk_if;
  import sccs_pkg::*;
  logic oscOut;
  sccs_src_t desired;
  logic extLvl;
  logic rtcLvl;
  logic sysClk;
  sccs_src_t active;

  modport ctl (
    output oscOut,
    output desired,
    output extLvl,
    output rtcLvl,
    input sysClk,
    input active
  );

  modport mux (
    input oscOut,
    input desired,
    input extLvl,
    input rtcLvl,
    output sysClk,
    output active
  );
endinterface

// File: hdl/sccs_clk_mux.sv
// Oscillator divider and glitch-free system clock source multiplexer
module sccs_clk_mux (
  input wire logic ref_clk,
  input wire logic arst_n,
  sccs_clk_if.mux cif
);
  import sccs_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic divLvl;
    sccs_src_t active;
    logic sysClk;
  } sccs_mux_state_t;

  sccs_mux_state_t s;
  sccs_mux_state_t next_s;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] divLimit(input sccs_src_t src);
    case (src)
      SRC_DIV2: divLimit = DIV2_LIMIT;
      SRC_DIV4: divLimit = DIV4_LIMIT;
      SRC_DIV8: divLimit = DIV8_LIMIT;
      default: divLimit = DIV1_LIMIT;
    endcase
  endfunction

  function automatic logic srcLevel(input sccs_src_t src, input logic dl,
                                    input logic ext, input logic rtc);
    case (src)
      SRC_EXT: srcLevel = ext;
      SRC_RTC: srcLevel = rtc;
      default: srcLevel = dl;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Gated oscillator parks the divider low so a later switch is clean
    if (!cif.oscOut) begin
      next_s.cnt = 3'h0;
      next_s.divLvl = 1'b0;
    end else if (s.cnt >= divLimit(s.active)) begin
      next_s.cnt = 3'h0;
      next_s.divLvl = ~s.divLvl;
    end else begin
      next_s.cnt = 3'(s.cnt + 3'h1);
    end
    // Hand over only while both old and new sources sit low: no runts
    if (s.active != cif.desired && !s.sysClk &&
        !srcLevel(cif.desired, s.divLvl, cif.extLvl, cif.rtcLvl)) begin
      next_s.active = cif.desired;
    end
    next_s.sysClk = srcLevel(next_s.active, next_s.divLvl, cif.extLvl,
                             cif.rtcLvl);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{cnt: 3'h0, divLvl: 1'b0, active: SRC_DIV1, sysClk: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign cif.sysClk = s.sysClk;
  assign cif.active = s.active;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_no_runt_switch: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $changed(s.active) |-> !$past(s.sysClk))
    else $error("Source switched while clock was high");

  a_ext_follows_pin: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (s.active == SRC_EXT) && $past(s.active == SRC_EXT)
      |-> s.sysClk == $past(cif.extLvl))
    else $error("External source not followed");

  a_override_takes: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (cif.desired == SRC_EXT) && (s.active != SRC_EXT) && !s.sysClk &&
      !cif.extLvl |=> s.active == SRC_EXT)
    else $error("External clock not taken when allowed");

  a_div2_period: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (s.active == SRC_DIV2) && cif.oscOut && $rose(s.divLvl) ##1
      (cif.oscOut && s.active == SRC_DIV2)
      |-> s.divLvl ##1 !s.divLvl)
    else $error("Divide by two half period wrong");

endmodule

// File: hdl/sccs_clock_control.sv
// System clock source select, oscillator control and revision registers
// ---------------------------------------------------------------
// Overview of operation
// ---------------------------------------------------------------
// Overview of operation
// - Any reset selects the undivided internal oscillator as clock.
// - The 3-bit select picks osc/1,/2,/4,/8, the clock pin or the RTC.
// - The override input forces the clock pin regardless of select.
// - Unused upper bits of both registers read zero and ignore writes.
// - Force-on keeps the oscillator on while power is enabled; clear without pin control gates only its output.
// - Power enable low removes oscillator power altogether.
// - With pin control and no force-on, pin rise stops, fall restarts.
// - An 8-bit revision register resets to the silicon revision and is overwritten by writes.
module sccs_clock_control #(
  parameter logic [7:0] REVISION_ID = 8'hA5 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic extClkPin,
  input wire logic rtcOscPin,
  input wire logic externalClockOverride,
  output logic sysClk,
  output sccs_pkg::sccs_src_t activeSource,
  output logic oscPowerOn,
  output logic oscRunning,
  output logic oscClkOut
);
  import sccs_pkg::*;

  typedef struct packed {
    logic [2:0] clock_source_select_reg;
    logic oscForceOn;
    logic oscPowerEnable;
    logic oscPinControlEnable;
    logic [7:0] revision;
    logic extMeta;
    logic extSync;
    logic extPrev;
    logic rtcMeta;
    logic rtcSync;
    logic pinOff;
    logic [7:0] rdData;
    logic powerOn;
    logic running;
    logic clkOut;
  } sccs_ctl_state_t;

  sccs_ctl_state_t s;
  sccs_ctl_state_t next_s;
  sccs_clk_if cif ();

  // ---------------------------------------------------------------
  // Register read decode
  // ---------------------------------------------------------------
  function automatic logic [7:0] readReg(input logic [7:0] addr,
                                         input sccs_ctl_state_t st);
    if (addr == ADDR_CLK_SELECT) begin
      readReg = {5'h00, st.clock_source_select_reg};
    end else if (addr == ADDR_OSC_CTRL) begin
      readReg = {5'h00, st.oscForceOn, st.oscPowerEnable,
                 st.oscPinControlEnable};
    end else if (addr == ADDR_REVISION) begin
      readReg = st.revision;
    end else begin
      readReg = UNMAPPED_READ;
    end
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.extMeta = extClkPin;
    next_s.extSync = s.extMeta;
    next_s.extPrev = s.extSync;
    next_s.rtcMeta = rtcOscPin;
    next_s.rtcSync = s.rtcMeta;

    if (regWrEn) begin
      if (regAddr == ADDR_CLK_SELECT) begin
        // Reserved codes are dropped so the running source stays put
        if (regWrData[2:0] <= SRC_RTC) begin
          next_s.clock_source_select_reg = regWrData[2:0];
        end
      end else if (regAddr == ADDR_OSC_CTRL) begin
        next_s.oscForceOn = regWrData[OSC_FORCE_ON_BIT];
        next_s.oscPowerEnable = regWrData[OSC_POWER_BIT];
        next_s.oscPinControlEnable = regWrData[OSC_PIN_BIT];
      end else if (regAddr == ADDR_REVISION) begin
        next_s.revision = regWrData;
      end
    end

    if (regRdEn) begin
      next_s.rdData = readReg(regAddr, s);
    end

    // Pin gating only acts while force-on is clear
    if (!(s.oscPinControlEnable && !s.oscForceOn)) begin
      next_s.pinOff = 1'b0;
    end else if (s.extSync && !s.extPrev) begin
      next_s.pinOff = 1'b1;
    end else if (!s.extSync && s.extPrev) begin
      next_s.pinOff = 1'b0;
    end

    next_s.powerOn = next_s.oscPowerEnable;
    next_s.running = next_s.oscPowerEnable &&
      !(next_s.oscPinControlEnable && !next_s.oscForceOn &&
        next_s.pinOff);
    // Without force-on or pin control the output is gated, osc stays up
    next_s.clkOut = next_s.running &&
      (next_s.oscForceOn || next_s.oscPinControlEnable);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{
        clock_source_select_reg: CLK_SELECT_RST,
        oscForceOn: OSC_CTRL_RST[OSC_FORCE_ON_BIT],
        oscPowerEnable: OSC_CTRL_RST[OSC_POWER_BIT],
        oscPinControlEnable: OSC_CTRL_RST[OSC_PIN_BIT],
        revision: REVISION_ID,
        extMeta: 1'b0,
        extSync: 1'b0,
        extPrev: 1'b0,
        rtcMeta: 1'b0,
        rtcSync: 1'b0,
        pinOff: 1'b0,
        rdData: 8'h00,
        powerOn: OSC_CTRL_RST[OSC_POWER_BIT],
        running: OSC_CTRL_RST[OSC_POWER_BIT],
        clkOut: OSC_CTRL_RST[OSC_POWER_BIT]
      };
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Clock multiplexer
  // ---------------------------------------------------------------
  assign cif.oscOut = s.clkOut;
  assign cif.desired = externalClockOverride ? SRC_EXT :
                       sccs_src_t'(s.clock_source_select_reg);
  assign cif.extLvl = s.extSync;
  assign cif.rtcLvl = s.rtcSync;

  sccs_clk_mux u_mux (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .cif(cif)
  );

  assign regRdData = s.rdData;
  assign sysClk = cif.sysClk;
  assign activeSource = cif.active;
  assign oscPowerOn = s.powerOn;
  assign oscRunning = s.running;
  assign oscClkOut = s.clkOut;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_reset_div1_source: assert property (
    @(posedge ref_clk)
    $rose(arst_n) |-> activeSource == SRC_DIV1 && s.clock_source_select_reg == 3'h0)
    else $error("Reset did not select undivided oscillator");

  a_sel_upper_zero: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    regRdEn && regAddr == ADDR_CLK_SELECT |=> regRdData[7:3] == 5'h00)
    else $error("Select register upper bits not zero");

  a_osc_upper_zero: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    regRdEn && regAddr == ADDR_OSC_CTRL |=> regRdData[7:3] == 5'h00)
    else $error("Oscillator control upper bits not zero");

  a_osc_ctrl_write: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    regWrEn && regAddr == ADDR_OSC_CTRL ##1 regRdEn &&
      regAddr == ADDR_OSC_CTRL
      |=> regRdData == {5'h00, $past(regWrData[2:0], 2)})
    else $error("Oscillator control readback wrong");

  a_reserved_kept: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    regWrEn && regAddr == ADDR_CLK_SELECT && regWrData[2:0] > SRC_RTC
      |=> $stable(s.clock_source_select_reg))
    else $error("Reserved select code was taken");

  a_power_removed: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !s.oscPowerEnable |-> !oscPowerOn && !oscRunning && !oscClkOut)
    else $error("Oscillator powered while disabled");

  a_output_gated: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    s.oscPowerEnable && !s.oscForceOn && !s.oscPinControlEnable
      |-> oscRunning && !oscClkOut)
    else $error("Gating with force-on clear is wrong");

  sequence pinRise;
    s.oscPowerEnable && s.oscPinControlEnable && !s.oscForceOn &&
      s.extSync && !s.extPrev;
  endsequence

  a_pin_rise_stops: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    pinRise ##1 (s.oscPinControlEnable && !s.oscForceOn && s.extSync)
      |-> !oscRunning && !oscClkOut)
    else $error("Pin rise did not stop oscillator");

  a_pin_fall_restarts: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    s.oscPowerEnable && s.oscPinControlEnable && !s.oscForceOn &&
      !s.extSync && s.extPrev |=> oscRunning == s.oscPowerEnable)
    else $error("Pin fall did not restart oscillator");

  a_override_target: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    externalClockOverride && activeSource == SRC_EXT
      |=> activeSource == SRC_EXT)
    else $error("Override did not hold external clock");

endmodule

// File: tb/sccs_clock_control_test.sv
// Self-checking testbench for the system clock select block
module sccs_clock_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sccs_pkg::*;

  // ---------------------------------------------------------------
  // Signals and design instance
  // ---------------------------------------------------------------
  localparam logic [7:0] REV = 8'h3C; // Arbitrary value
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic regWrEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic extClkPin = 1'b0;
  logic rtcOscPin = 1'b0;
  logic externalClockOverride = 1'b0;
  logic sysClk;
  sccs_src_t activeSource;
  logic oscPowerOn;
  logic oscRunning;
  logic oscClkOut;
  logic extRun = 1'b1;
  logic extHold = 1'b0;
  logic [3:0] cnt = 4'h0;
  int errCount = 0;
  int cmpCount = 0;

  sccs_clock_control #(.REVISION_ID(REV)) i_dut (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .regAddr(regAddr),
    .regWrEn(regWrEn),
    .regWrData(regWrData),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .extClkPin(extClkPin),
    .rtcOscPin(rtcOscPin),
    .externalClockOverride(externalClockOverride),
    .sysClk(sysClk),
    .activeSource(activeSource),
    .oscPowerOn(oscPowerOn),
    .oscRunning(oscRunning),
    .oscClkOut(oscClkOut)
  );

  always #4 ref_clk = ~ref_clk;

  // Pin clock half period 4 cycles, RTC half period 8 cycles
  always @(posedge ref_clk) begin
    cnt <= cnt + 4'h1;
    extClkPin <= extRun ? cnt[2] : extHold;
    rtcOscPin <= cnt[3];
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1;
    chk("regRdData", regRdData, e);
  endtask

  // Write and read back on consecutive edges, as the bus allows
  task automatic wrRd(input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1;
    chk("regRdData", regRdData, e);
  endtask

  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask

  // Switching waits for low levels, so allow a bounded wait
  task automatic waitSrc(input sccs_src_t e);
    for (int i = 0; i < 64 && activeSource !== e; i++) settle();
    chk("activeSource", {5'h00, activeSource}, {5'h00, e});
  endtask

  task automatic waitRun(input logic e);
    for (int i = 0; i < 8 && oscRunning !== e; i++) settle();
    chk("oscRunning", {7'h00, oscRunning}, {7'h00, e});
  endtask

  task automatic halfPer(input logic [7:0] e);
    logic prev;
    int n;
    settle();
    prev = sysClk;
    n = 0;
    while (sysClk === prev && n < 40) begin
      settle();
      n++;
    end
    prev = sysClk;
    n = 0;
    while (sysClk === prev && n < 40) begin
      settle();
      n++;
    end
    chk("sysClk half period", 8'(n), e);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (16) @(posedge ref_clk);
    #1;
    chk("resetSource", {5'h00, activeSource}, 8'h00);
    chk("resetPower", {7'h00, oscPowerOn}, 8'h01);
    @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(ADDR_CLK_SELECT, 8'h00);
    rd(ADDR_OSC_CTRL, 8'h06);
    rd(ADDR_REVISION, REV);
    $display("test reset done");
  endtask

  task automatic t_select();
    logic [7:0] half [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h04, 8'h08};
    for (int c = 0; c < 6; c++) begin
      wr(ADDR_CLK_SELECT, {5'h1F, 3'(c)});
      rd(ADDR_CLK_SELECT, {5'h00, 3'(c)});
      waitSrc(sccs_src_t'(c));
      halfPer(half[c]);
    end
    wr(ADDR_CLK_SELECT, 8'h06);
    wr(ADDR_CLK_SELECT, 8'h07);
    rd(ADDR_CLK_SELECT, 8'h05);
    chk("reservedKeeps", {5'h00, activeSource}, 8'h05);
    wr(8'h35, 8'hFF);
    rd(8'h35, UNMAPPED_READ);
    rd(ADDR_CLK_SELECT, 8'h05);
    $display("test select done");
  endtask

  task automatic t_override();
    wr(ADDR_CLK_SELECT, 8'h00);
    waitSrc(SRC_DIV1);
    @(posedge ref_clk);
    externalClockOverride <= 1'b1;
    waitSrc(SRC_EXT);
    halfPer(8'h04);
    @(posedge ref_clk);
    externalClockOverride <= 1'b0;
    waitSrc(SRC_DIV1);
    $display("test override done");
  endtask

  task automatic t_osc();
    // Bit 3 is written as zero, the rest of the upper bits set
    wrRd(ADDR_OSC_CTRL, 8'hF7, 8'h07);
    wr(ADDR_OSC_CTRL, 8'h02);
    settle();
    chk("gatedOut", {7'h00, oscClkOut}, 8'h00);
    chk("gatedRun", {7'h00, oscRunning}, 8'h01);
    chk("gatedPower", {7'h00, oscPowerOn}, 8'h01);
    wr(ADDR_OSC_CTRL, 8'h06);
    settle();
    chk("forcedOut", {7'h00, oscClkOut}, 8'h01);
    @(posedge ref_clk);
    extRun <= 1'b0;
    extHold <= 1'b0;
    wr(ADDR_OSC_CTRL, 8'h07);
    wr(ADDR_OSC_CTRL, 8'h03);
    waitRun(1'b1);
    @(posedge ref_clk);
    extHold <= 1'b1;
    waitRun(1'b0);
    repeat (6) settle();
    chk("stayStopped", {7'h00, oscRunning}, 8'h00);
    @(posedge ref_clk);
    extHold <= 1'b0;
    waitRun(1'b1);
    wr(ADDR_OSC_CTRL, 8'h06);
    @(posedge ref_clk);
    extRun <= 1'b1;
    wr(ADDR_CLK_SELECT, 8'h04);
    waitSrc(SRC_EXT);
    wr(ADDR_OSC_CTRL, 8'h00);
    settle();
    chk("powerOff", {7'h00, oscPowerOn}, 8'h00);
    rd(ADDR_OSC_CTRL, 8'h00);
    halfPer(8'h04);
    wr(ADDR_REVISION, 8'h5A);
    rd(ADDR_REVISION, 8'h5A);
    $display("test oscillator done");
  endtask

  // ---------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic endSim();
    $display("comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    t_reset();
    t_select();
    t_override();
    t_osc();
    t_reset();
    endSim();
  end

  // Whole run is well under two thousand cycles; this span is far beyond it
  initial begin
    #200us;
    errCount++;
    endSim();
  end
endmodule
